/* File: hw/acs_conv_seq.v */
`timescale 1ns/1ps
`default_nettype none
module acs_conv_seq #(
  parameter [15:0] CONV_CYCLES = 16'h0010
)(
  // clocking
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // control
  input  wire        start_set,
  input  wire        start_clr,
  input  wire        awake,
  input  wire        one_shot,
  input  wire        sw_trigger,
  // state
  output reg         busy,
  output reg         done
);
  reg [15:0] count;
  // one conversion timer; a clear stops it unless a qualified set comes with it, a set restarts it only when awake with software trigger
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= 16'h0000;
    end
    else if (ce)
    begin
      if (start_set && awake && sw_trigger)
      begin
        busy  <= 1'b1;
        done  <= 1'b0;
        count <= CONV_CYCLES;
      end
      else if (start_clr || !awake)
        busy <= 1'b0;
      else if (busy)
      begin
        if (count == 16'h0001)
        begin
          busy <= !one_shot;
          done <= 1'b1;
          count <= CONV_CYCLES;
        end
        else
          count <= count - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/acs_defs.vh */
// Summary of operation
// - protect bit 3 gates reference/monitor writes
// - reference switch bit 0 low isolates reference
// - divide field 10 gives converter clock /2
// - source bit 0 picks base peripheral clock
// - mode field 000 means one-shot
// - trigger field 00 means software start only
// - channel field 000 routes channel zero
// - group field 00 picks port zero group
// - extended input bit 0 keeps it deselected
// - resolution bit: 1 ten-bit, 0 eight-bit
// - wake bit 1 leaves standby
// - assist bit enables open-circuit assist
// - start flag 1 converts, 0 stops
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
`define ACS_OFF_PROTECT   8'h00
`define ACS_OFF_REFSW     8'h04
`define ACS_OFF_MON0      8'h08
`define ACS_OFF_MON4      8'h18
`define ACS_OFF_MODE      8'h1C
`define ACS_OFF_INSEL     8'h20
`define ACS_OFF_CTRL0     8'h24
`define ACS_OFF_CTRL1     8'h28
`define ACS_OFF_STATUS    8'h2C
`define ACS_BIT_MONWE     3
`define ACS_BIT_REFCON    0
`define ACS_BIT_SRC       2
`define ACS_BIT_EXT       0
`define ACS_BIT_RES       4
`define ACS_BIT_WAKE      5
`define ACS_BIT_ASSIST    6
`define ACS_BIT_START     0
`define ACS_RST_BYTE      8'h00
`define ACS_RESP_OKAY     2'b00
`define ACS_RESP_SLVERR   2'b10
`define ACS_CONV_CYCLES   16'h0010
`endif

/* File: hw/acs_reg8.v */
`timescale 1ns/1ps
`default_nettype none
module acs_reg8 #(
  parameter [7:0] RESET_VALUE = 8'h00
)(
  // clocking
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  // write side
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  input  wire [7:0] wr_mask,
  // value
  output reg  [7:0] q
);
  // masked byte store, frozen while clock enable is low
  always @(posedge aclk)
  begin
    if (!aresetn)
      q <= RESET_VALUE;
    else if (ce && wr_en)
      q <= (q & ~wr_mask) | (wr_data & wr_mask);
  end
endmodule
`default_nettype wire

/* File: hw/acs_top.v */
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"
module acs_top #(
  parameter [15:0] CONV_CYCLES = `ACS_CONV_CYCLES
)(
  // clocking
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // converter controls
  output wire        reference_to_input_connect,
  output wire [1:0]  clock_divide_sel,
  output wire        clock_source_pick,
  output wire [2:0]  op_mode_sel,
  output wire [1:0]  trigger_pick_sel,
  output wire [2:0]  channel_pick_sel,
  output wire [1:0]  input_group_pick,
  output wire        extended_input_pick,
  output wire        resolution_ten_bit,
  output wire        converter_wake,
  output wire        open_circuit_assist_enable,
  output wire        converting,
  output wire [39:0] monitor_ctrl_bytes
);
  // write channel holding
  reg        aw_held;
  reg [7:0]  aw_addr;
  reg        w_held;
  reg [7:0]  w_byte;
  reg        w_lane0;
  // write/read fire strobes, decode hits and read byte
  wire       wr_fire;
  wire       rd_fire;
  reg        wr_hit;
  reg  [7:0] rd_byte;
  reg        rd_hit;

  wire [7:0] write_protect_ctrl;
  wire [7:0] reference_switch_ctrl;
  wire [7:0] converter_mode_ctrl;
  wire [7:0] converter_input_select;
  wire [7:0] converter_control_one;
  wire [7:0] converter_control_zero;
  wire       conv_busy;
  wire       conv_done;

  // each address and data taken once, in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held && w_held && ce;
  assign rd_fire = s_axi_arvalid && s_axi_arready && ce;

  // capture write address and data
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // protected set: reference switch and the five monitor bytes
  wire mon_we = write_protect_ctrl[`ACS_BIT_MONWE];
  wire [7:0] lane_mask = w_lane0 ? 8'hFF : 8'h00;

  // address decode; a blocked protected write is acked but dropped
  always @*
  begin
    wr_hit = 1'b0;
    case ({aw_addr[7:2], 2'b00})
      `ACS_OFF_PROTECT, `ACS_OFF_REFSW, `ACS_OFF_MODE, `ACS_OFF_INSEL,
      `ACS_OFF_CTRL0, `ACS_OFF_CTRL1, `ACS_OFF_STATUS: wr_hit = 1'b1;
      default: wr_hit = (aw_addr >= `ACS_OFF_MON0) && (aw_addr <= (`ACS_OFF_MON4 + 8'h03));
    endcase
  end

  wire wr_prot  = wr_fire && ({aw_addr[7:2], 2'b00} == `ACS_OFF_PROTECT);
  wire wr_ref   = wr_fire && ({aw_addr[7:2], 2'b00} == `ACS_OFF_REFSW) && mon_we;
  wire wr_mode  = wr_fire && ({aw_addr[7:2], 2'b00} == `ACS_OFF_MODE);
  wire wr_insel = wr_fire && ({aw_addr[7:2], 2'b00} == `ACS_OFF_INSEL);
  wire wr_c0    = wr_fire && ({aw_addr[7:2], 2'b00} == `ACS_OFF_CTRL0);
  wire wr_c1    = wr_fire && ({aw_addr[7:2], 2'b00} == `ACS_OFF_CTRL1);

  acs_reg8 u_prot (.aclk(aclk), .aresetn(aresetn), .ce(ce), .wr_en(wr_prot),
    .wr_data(w_byte), .wr_mask(lane_mask), .q(write_protect_ctrl));
  acs_reg8 u_ref (.aclk(aclk), .aresetn(aresetn), .ce(ce), .wr_en(wr_ref),
    .wr_data(w_byte), .wr_mask(lane_mask), .q(reference_switch_ctrl));
  acs_reg8 u_mode (.aclk(aclk), .aresetn(aresetn), .ce(ce), .wr_en(wr_mode),
    .wr_data(w_byte), .wr_mask(lane_mask), .q(converter_mode_ctrl));
  acs_reg8 u_insel (.aclk(aclk), .aresetn(aresetn), .ce(ce), .wr_en(wr_insel),
    .wr_data(w_byte), .wr_mask(lane_mask), .q(converter_input_select));
  acs_reg8 u_c1 (.aclk(aclk), .aresetn(aresetn), .ce(ce), .wr_en(wr_c1),
    .wr_data(w_byte), .wr_mask(lane_mask), .q(converter_control_one));

  // five voltage-monitor bytes, all behind the same gate
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_mon
      // byte address of this monitor slot, kept at full width for the compare
      localparam integer MON_OFF = `ACS_OFF_MON0 + 4 * gi;
      wire wr_mon = wr_fire && mon_we &&
        ({24'h00_0000, aw_addr[7:2], 2'b00} == MON_OFF);
      acs_reg8 u_mon (.aclk(aclk), .aresetn(aresetn), .ce(ce), .wr_en(wr_mon),
        .wr_data(w_byte), .wr_mask(lane_mask), .q(monitor_ctrl_bytes[gi*8 +: 8]));
    end
  endgenerate

  // control zero: start flag readback follows the sequencer
  wire start_set = wr_c0 && w_lane0 && w_byte[`ACS_BIT_START];
  wire start_clr = wr_c0 && w_lane0 && !w_byte[`ACS_BIT_START];
  assign converter_control_zero = {7'b000_0000, conv_busy};

  acs_conv_seq #(.CONV_CYCLES(CONV_CYCLES)) u_seq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .start_set  (start_set),
    .start_clr  (start_clr),
    .awake      (converter_wake),
    .one_shot   (op_mode_sel == 3'b000),
    .sw_trigger (trigger_pick_sel == 2'b00),
    .busy       (conv_busy),
    .done       (conv_done)
  );

  // field breakout to the analog core
  assign reference_to_input_connect = reference_switch_ctrl[`ACS_BIT_REFCON];
  assign clock_divide_sel           = converter_mode_ctrl[1:0];
  assign clock_source_pick          = converter_mode_ctrl[`ACS_BIT_SRC];
  assign op_mode_sel                = converter_mode_ctrl[5:3];
  assign trigger_pick_sel           = converter_mode_ctrl[7:6];
  assign channel_pick_sel           = converter_input_select[2:0];
  assign input_group_pick           = converter_input_select[7:6];
  assign extended_input_pick        = converter_control_one[`ACS_BIT_EXT];
  assign resolution_ten_bit         = converter_control_one[`ACS_BIT_RES];
  assign converter_wake             = converter_control_one[`ACS_BIT_WAKE];
  assign open_circuit_assist_enable = converter_control_one[`ACS_BIT_ASSIST];
  assign converting                 = conv_busy;

  // write response one cycle after both halves are in
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ACS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read mux; protected registers always readable
  always @*
  begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `ACS_OFF_PROTECT: rd_byte = write_protect_ctrl;
      `ACS_OFF_REFSW:   rd_byte = reference_switch_ctrl;
      `ACS_OFF_MODE:    rd_byte = converter_mode_ctrl;
      `ACS_OFF_INSEL:   rd_byte = converter_input_select;
      `ACS_OFF_CTRL0:   rd_byte = converter_control_zero;
      `ACS_OFF_CTRL1:   rd_byte = converter_control_one;
      `ACS_OFF_STATUS:  rd_byte = {6'b00_0000, conv_done, conv_busy};
      default:
      begin
        if (s_axi_araddr >= `ACS_OFF_MON0 && s_axi_araddr <= (`ACS_OFF_MON4 + 8'h03))
          rd_byte = monitor_ctrl_bytes[((s_axi_araddr - `ACS_OFF_MON0) >> 2) * 8 +: 8];
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  // read data registered, held until taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ACS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/acs_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_top_properties (
  // clocking
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  // bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // converter controls
  input wire logic        reference_to_input_connect,
  input wire logic [1:0]  trigger_pick_sel,
  input wire logic        converter_wake,
  input wire logic        converting,
  input wire logic [39:0] monitor_ctrl_bytes
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // answers stand until taken
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read not answered");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while answering");
  // gated bytes move only with an accepted write
  gated_write_a: assert property ($changed({reference_to_input_connect, monitor_ctrl_bytes}) |->
    $rose(s_axi_bvalid) && s_axi_bresp == 2'b00) else $error("gated byte moved");
  start_gate_a: assert property ($rose(converting) |-> converter_wake && trigger_pick_sel == 2'b00)
    else $error("start while asleep or hw trigger");
  sleep_stop_a: assert property ($fell(converter_wake) |-> ##[0:2] !converting)
    else $error("converting while asleep");
  // a low clock enable holds the converting and both answer-valid bits still
  ce_freeze_a: assert property (!ce |=> $stable(converting) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
    else $error("state moved while clock enable low");
endmodule
bind acs_top acs_top_properties i_acs_top_properties (
  .aclk                       (aclk),
  .aresetn                    (aresetn),
  .ce                         (ce),
  .s_axi_awready              (s_axi_awready),
  .s_axi_bvalid               (s_axi_bvalid),
  .s_axi_bready               (s_axi_bready),
  .s_axi_bresp                (s_axi_bresp),
  .s_axi_arvalid              (s_axi_arvalid),
  .s_axi_arready              (s_axi_arready),
  .s_axi_rvalid               (s_axi_rvalid),
  .s_axi_rready               (s_axi_rready),
  .s_axi_rdata                (s_axi_rdata),
  .reference_to_input_connect (reference_to_input_connect),
  .trigger_pick_sel           (trigger_pick_sel),
  .converter_wake             (converter_wake),
  .converting                 (converting),
  .monitor_ctrl_bytes         (monitor_ctrl_bytes)
);
`default_nettype wire

/* File: tb/adc_setup_and_write_protect_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_setup_and_write_protect_bench;
  // stimulus and observed ports
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, v, mon [0:4];
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clock_source_pick;
  wire         reference_to_input_connect, extended_input_pick, resolution_ten_bit, converter_wake;
  wire         open_circuit_assist_enable, converting;
  wire [1:0]   s_axi_bresp, s_axi_rresp, clock_divide_sel, trigger_pick_sel, input_group_pick;
  wire [2:0]   op_mode_sel, channel_pick_sel;
  wire [31:0]  s_axi_rdata;
  wire [39:0]  monitor_ctrl_bytes;
  int          n_fail, checks, n, i;
  integer      seed = 32'hfe82_a469;

  // short count keeps the run brief
  acs_top #(.CONV_CYCLES(16'h0008)) i_acs_top (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .reference_to_input_connect(reference_to_input_connect), .clock_divide_sel(clock_divide_sel),
    .clock_source_pick(clock_source_pick), .op_mode_sel(op_mode_sel), .trigger_pick_sel(trigger_pick_sel),
    .channel_pick_sel(channel_pick_sel), .input_group_pick(input_group_pick),
    .extended_input_pick(extended_input_pick), .resolution_ten_bit(resolution_ten_bit),
    .converter_wake(converter_wake), .open_circuit_assist_enable(open_circuit_assist_enable),
    .converting(converting), .monitor_ctrl_bytes(monitor_ctrl_bytes)
  );

  // expected field views of a byte written to input select and control one
  function automatic logic [4:0] insel_view(input logic [7:0] b);
    return {b[7:6], b[2:0]};
  endfunction

  function automatic logic [3:0] ctrl1_view(input logic [7:0] b);
    return {b[6:4], b[0]};
  endfunction

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a limit that runs out ends the run
  task tmo(input logic ok);
    if (!ok)
    begin
      n_fail++;
      stop_test;
    end
  endtask

  // handshakes are judged at the falling edge, where outputs have settled,
  // and acted on by non-blocking assignment just after the next rising edge
  // upper data bits are random: only the low byte is stored
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
    logic       aw_go;
    logic       w_go;
    logic       b_go;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= $random(seed) & 32'hffff_ff00 | d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    b_go = 1'b0;
    rsp = 2'b11;
    for (n = 0; !b_go && n < 40; n++)
    begin
      @(negedge aclk);
      aw_go = s_axi_awvalid && s_axi_awready && ce;
      w_go = s_axi_wvalid && s_axi_wready && ce;
      b_go = s_axi_bvalid && s_axi_bready && ce;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
      if (b_go) s_axi_bready <= 1'b0;
    end
    tmo(b_go);
    chk("bresp", er, rsp);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = 2'b00);
    logic        ar_go;
    logic        r_go;
    logic [31:0] dat;
    logic [1:0]  rsp;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    r_go = 1'b0;
    dat = 32'h0000_0000;
    rsp = 2'b11;
    for (n = 0; !r_go && n < 40; n++)
    begin
      @(negedge aclk);
      ar_go = s_axi_arvalid && s_axi_arready && ce;
      r_go = s_axi_rvalid && s_axi_rready && ce;
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_go) s_axi_arvalid <= 1'b0;
      if (r_go) s_axi_rready <= 1'b0;
    end
    tmo(r_go);
    chk("rdata", e, dat);
    chk("rresp", er, rsp);
  endtask

  task wait_conv(input logic lvl);
    for (n = 0; converting !== lvl && n < 40; n++)
      @(negedge aclk);
    tmo(converting === lvl);
  endtask

  // main sequence
  initial
  begin
    {ce, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h40;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'h1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h1C, 8'h00);
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h00);
    wr(8'h00, 8'h08);
    wr(8'h04, 8'h01);
    chk("refsw", 1, reference_to_input_connect);
    wr(8'h04, 8'h00);
    chk("refsw", 0, reference_to_input_connect);
    for (i = 0; i < 5; i++)
    begin
      mon[i] = $random(seed);
      wr(8'(8 + 4 * i), mon[i]);
    end
    wr(8'h00, 8'h00);
    wr(8'h10, ~mon[2]);
    rd(8'h10, mon[2]);
    chk("monitors", {mon[4], mon[3], mon[2], mon[1], mon[0]}, monitor_ctrl_bytes);
    // corner bytes first, then random ones
    for (i = 0; i < 20; i++)
    begin
      v = (i == 0) ? 8'h02 : (i == 1) ? 8'h00 : $random(seed);
      wr(8'h1C, v);
      wr(8'h20, v);
      wr(8'h28, v);
      chk("mode", v, {trigger_pick_sel, op_mode_sel, clock_source_pick, clock_divide_sel});
      chk("insel", insel_view(v), {input_group_pick, channel_pick_sel});
      chk("ctrl1", ctrl1_view(v),
          {open_circuit_assist_enable, converter_wake, resolution_ten_bit, extended_input_pick});
    end
    wr(8'h30, 8'h01, 2'b10);
    rd(8'hFC, 8'h00, 2'b10);
    // one-shot, repeat stopped by flag, repeat stopped by standby
    wr(8'h28, 8'h20);
    wr(8'h1C, 8'h00);
    wr(8'h24, 8'h01);
    wait_conv(1'b1);
    wait_conv(1'b0);
    rd(8'h2C, 8'h02);
    // a low clock enable must hold a one-shot conversion mid-way
    wr(8'h24, 8'h01);
    wait_conv(1'b1);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (20) @(posedge aclk);
    chk("frozen", 1, converting);
    ce <= 1'b1;
    wait_conv(1'b0);
    wr(8'h1C, 8'h08);
    wr(8'h24, 8'h01);
    repeat (30) @(posedge aclk);
    chk("converting", 1, converting);
    wr(8'h24, 8'h00);
    wait_conv(1'b0);
    wr(8'h24, 8'h01);
    wait_conv(1'b1);
    wr(8'h28, 8'h00);
    wait_conv(1'b0);
    wr(8'h1C, 8'h40);
    wr(8'h28, 8'h20);
    wr(8'h24, 8'h01);
    repeat (4) @(posedge aclk);
    chk("converting", 0, converting);
    stop_test;
  end
endmodule
`default_nettype wire
